// ===== clp_pkg.sv
// constants for the closed-loop settings register slice
// assumes a single 100 MHz clock and a simple synchronous register port
package clp_pkg;
    localparam int unsigned CLP_ADDR_W = 8;
    localparam int unsigned CLP_DATA_W = 32;

    // word addresses on the register port
    localparam logic [7:0] CLP_ADDR_ONE = 8'h84;
    localparam logic [7:0] CLP_ADDR_TWO = 8'h88;

    localparam logic [31:0] CLP_RESET_ONE = 32'h00000000;
    localparam logic [31:0] CLP_RESET_TWO = 32'h00000000;
    localparam logic [31:0] CLP_READ_NONE = 32'h00000000;

    // shared by both words
    localparam int unsigned CLP_PARITY_BIT = 31;

    // word one fields
    localparam int unsigned CLP_FREQ_HI = 17;
    localparam int unsigned CLP_FREQ_LO = 13;
    localparam int unsigned CLP_MOD_HI = 12;
    localparam int unsigned CLP_MOD_LO = 11;
    localparam int unsigned CLP_COMPL_BIT = 10;
    localparam int unsigned CLP_SIGN_BIT = 9;
    localparam int unsigned CLP_LEAD_HI = 8;
    localparam int unsigned CLP_LEAD_LO = 1;

    // word two fields
    localparam int unsigned CLP_FBSEL_HI = 30;
    localparam int unsigned CLP_FBSEL_LO = 29;
    localparam int unsigned CLP_FBDIV_HI = 28;
    localparam int unsigned CLP_FBDIV_LO = 25;
    localparam int unsigned CLP_FBCFG_BIT = 24;
    localparam int unsigned CLP_FBTHR_HI = 23;
    localparam int unsigned CLP_FBTHR_LO = 21;
    localparam int unsigned CLP_STOP_HI = 20;
    localparam int unsigned CLP_STOP_LO = 18;
    localparam int unsigned CLP_BRKT_HI = 17;
    localparam int unsigned CLP_BRKT_LO = 14;
    localparam int unsigned CLP_SPIN_HI = 13;
    localparam int unsigned CLP_SPIN_LO = 11;
    localparam int unsigned CLP_DUTY_HI = 10;
    localparam int unsigned CLP_DUTY_LO = 8;
    localparam int unsigned CLP_SURGE_BIT = 7;
    localparam int unsigned CLP_CBC_HI = 6;
    localparam int unsigned CLP_CBC_LO = 3;

    // switching frequency decode, result in kHz
    localparam logic [4:0] CLP_FREQ_FINE_LAST = 5'h0F;
    localparam logic [4:0] CLP_FREQ_COARSE_FIRST = 5'h10;
    localparam logic [6:0] CLP_FREQ_FINE_BASE = 7'h05;
    localparam logic [6:0] CLP_FREQ_COARSE_BASE = 7'h19;
    localparam logic [6:0] CLP_FREQ_COARSE_STEP = 7'h05;

    // lead angle: 0.12 degree per count, reported in hundredths of a degree
    localparam logic [11:0] CLP_LEAD_CENTIDEG_STEP = 12'h00C;

    typedef enum logic [1:0] {
        CLP_MOD_HIGH_SIDE,
        CLP_MOD_LOW_SIDE,
        CLP_MOD_MIXED,
        CLP_MOD_INVALID
    } clp_mod_t;
endpackage : clp_pkg

// ===== clp_regs.sv
// closed-loop settings register slice: two read/write words and their decoded fields
// assumes a synchronous register port driven by the configuration interface logic
`timescale 1ns/10ps
module clp_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [clp_pkg::CLP_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [clp_pkg::CLP_DATA_W-1:0] reg_wdata,
    output logic [clp_pkg::CLP_DATA_W-1:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    // pwm controls from word one
    output logic [6:0] switching_frequency_khz,
    output logic [4:0] switching_frequency_sel,
    output clp_pkg::clp_mod_t modulation_side_sel,
    output logic modulation_invalid,
    output logic complementary_mode,
    output logic lead_sign,
    output logic [7:0] lead_magnitude,
    output logic [12:0] lead_angle_centideg,
    // controls from word two
    output logic [1:0] feedback_output_select,
    output logic [3:0] feedback_output_divider,
    output logic feedback_output_config,
    output logic [2:0] feedback_backemf_threshold,
    output logic [2:0] stop_method,
    output logic [3:0] stop_brake_time,
    output logic [2:0] active_spindown_threshold,
    output logic [2:0] brake_duty_limit,
    output logic surge_guard_enable,
    output logic [3:0] cycle_current_limit
);
    import clp_pkg::*;

    logic [31:0] closed_loop_settings_one;
    logic [31:0] closed_loop_settings_two;
    logic [31:0] next_one;
    logic [31:0] next_two;
    logic [31:0] next_rdata;
    logic next_ack;
    logic next_err;
    logic [6:0] next_freq_khz;
    logic [11:0] next_lead_abs;
    logic [12:0] next_lead_angle;
    logic [4:0] next_switching_frequency_sel;
    clp_mod_t next_modulation_side_sel;
    logic next_modulation_invalid;
    logic next_complementary_mode;
    logic next_lead_sign;
    logic [7:0] next_lead_magnitude;
    logic [1:0] next_feedback_output_select;
    logic [3:0] next_feedback_output_divider;
    logic next_feedback_output_config;
    logic [2:0] next_feedback_backemf_threshold;
    logic [2:0] next_stop_method;
    logic [3:0] next_stop_brake_time;
    logic [2:0] next_active_spindown_threshold;
    logic [2:0] next_brake_duty_limit;
    logic next_surge_guard_enable;
    logic [3:0] next_cycle_current_limit;
    logic hit_one;
    logic hit_two;
    logic wr_one;
    logic wr_two;

    // address decode and the port answer
    always_comb begin
        hit_one = (reg_addr == CLP_ADDR_ONE);
        hit_two = (reg_addr == CLP_ADDR_TWO);
        wr_one = reg_wr && hit_one;
        wr_two = reg_wr && hit_two;
        next_rdata = CLP_READ_NONE;
        next_ack = reg_wr | reg_rd;
        next_err = (reg_wr | reg_rd) & ~(hit_one | hit_two);
        // a read together with a write to the same word returns the old value
        if (reg_rd && hit_one) begin
            next_rdata = closed_loop_settings_one;
        end else if (reg_rd && hit_two) begin
            next_rdata = closed_loop_settings_two;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= CLP_READ_NONE;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_ack <= next_ack;
            reg_err <= next_err;
        end
    end

    // the two settings words, each stored whole
    clp_word #(
        .RESET_VALUE(CLP_RESET_ONE)
    ) u_word_one (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_one),
        .wdata(reg_wdata),
        .word(closed_loop_settings_one),
        .next_word(next_one)
    );

    clp_word #(
        .RESET_VALUE(CLP_RESET_TWO)
    ) u_word_two (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_two),
        .wdata(reg_wdata),
        .word(closed_loop_settings_two),
        .next_word(next_two)
    );

    // decoded controls, computed from the value being stored so they track the word
    always_comb begin
        next_switching_frequency_sel = next_one[CLP_FREQ_HI:CLP_FREQ_LO];
        // 1 kHz steps up to 20 kHz, then 5 kHz steps from 25 kHz
        if (next_switching_frequency_sel <= CLP_FREQ_FINE_LAST) begin
            next_freq_khz = CLP_FREQ_FINE_BASE + {2'h0, next_switching_frequency_sel};
        end else begin
            next_freq_khz = 7'(CLP_FREQ_COARSE_BASE + CLP_FREQ_COARSE_STEP
                * {2'h0, 5'(next_switching_frequency_sel - CLP_FREQ_COARSE_FIRST)});
        end
        next_modulation_side_sel = clp_mod_t'(next_one[CLP_MOD_HI:CLP_MOD_LO]);
        next_modulation_invalid = (next_modulation_side_sel == CLP_MOD_INVALID);
        next_complementary_mode = next_one[CLP_COMPL_BIT];
        next_lead_sign = next_one[CLP_SIGN_BIT];
        next_lead_magnitude = next_one[CLP_LEAD_HI:CLP_LEAD_LO];
        next_lead_abs = 12'({4'h0, next_lead_magnitude} * CLP_LEAD_CENTIDEG_STEP);
        // sign bit clear means the angle is applied negative
        if (next_lead_sign) begin
            next_lead_angle = {1'b0, next_lead_abs};
        end else begin
            next_lead_angle = 13'(-{1'b0, next_lead_abs});
        end
        next_feedback_output_select = next_two[CLP_FBSEL_HI:CLP_FBSEL_LO];
        next_feedback_output_divider = next_two[CLP_FBDIV_HI:CLP_FBDIV_LO];
        next_feedback_output_config = next_two[CLP_FBCFG_BIT];
        next_feedback_backemf_threshold = next_two[CLP_FBTHR_HI:CLP_FBTHR_LO];
        next_stop_method = next_two[CLP_STOP_HI:CLP_STOP_LO];
        next_stop_brake_time = next_two[CLP_BRKT_HI:CLP_BRKT_LO];
        next_active_spindown_threshold = next_two[CLP_SPIN_HI:CLP_SPIN_LO];
        next_brake_duty_limit = next_two[CLP_DUTY_HI:CLP_DUTY_LO];
        next_surge_guard_enable = next_two[CLP_SURGE_BIT];
        next_cycle_current_limit = next_two[CLP_CBC_HI:CLP_CBC_LO];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // outputs start as the decode of the reset words
            switching_frequency_khz <= CLP_FREQ_FINE_BASE;
            switching_frequency_sel <= CLP_RESET_ONE[CLP_FREQ_HI:CLP_FREQ_LO];
            modulation_side_sel <= clp_mod_t'(CLP_RESET_ONE[CLP_MOD_HI:CLP_MOD_LO]);
            modulation_invalid <= 1'b0;
            complementary_mode <= CLP_RESET_ONE[CLP_COMPL_BIT];
            lead_sign <= CLP_RESET_ONE[CLP_SIGN_BIT];
            lead_magnitude <= CLP_RESET_ONE[CLP_LEAD_HI:CLP_LEAD_LO];
            lead_angle_centideg <= '0;
            feedback_output_select <= CLP_RESET_TWO[CLP_FBSEL_HI:CLP_FBSEL_LO];
            feedback_output_divider <= CLP_RESET_TWO[CLP_FBDIV_HI:CLP_FBDIV_LO];
            feedback_output_config <= CLP_RESET_TWO[CLP_FBCFG_BIT];
            feedback_backemf_threshold <= CLP_RESET_TWO[CLP_FBTHR_HI:CLP_FBTHR_LO];
            stop_method <= CLP_RESET_TWO[CLP_STOP_HI:CLP_STOP_LO];
            stop_brake_time <= CLP_RESET_TWO[CLP_BRKT_HI:CLP_BRKT_LO];
            active_spindown_threshold <= CLP_RESET_TWO[CLP_SPIN_HI:CLP_SPIN_LO];
            brake_duty_limit <= CLP_RESET_TWO[CLP_DUTY_HI:CLP_DUTY_LO];
            surge_guard_enable <= CLP_RESET_TWO[CLP_SURGE_BIT];
            cycle_current_limit <= CLP_RESET_TWO[CLP_CBC_HI:CLP_CBC_LO];
        end else begin
            switching_frequency_khz <= next_freq_khz;
            switching_frequency_sel <= next_switching_frequency_sel;
            modulation_side_sel <= next_modulation_side_sel;
            modulation_invalid <= next_modulation_invalid;
            complementary_mode <= next_complementary_mode;
            lead_sign <= next_lead_sign;
            lead_magnitude <= next_lead_magnitude;
            lead_angle_centideg <= next_lead_angle;
            feedback_output_select <= next_feedback_output_select;
            feedback_output_divider <= next_feedback_output_divider;
            feedback_output_config <= next_feedback_output_config;
            feedback_backemf_threshold <= next_feedback_backemf_threshold;
            stop_method <= next_stop_method;
            stop_brake_time <= next_stop_brake_time;
            active_spindown_threshold <= next_active_spindown_threshold;
            brake_duty_limit <= next_brake_duty_limit;
            surge_guard_enable <= next_surge_guard_enable;
            cycle_current_limit <= next_cycle_current_limit;
        end
    end
endmodule : clp_regs

// one stored settings word: whole-word write, own reset value
module clp_word #(
    parameter logic [clp_pkg::CLP_DATA_W-1:0] RESET_VALUE = clp_pkg::CLP_RESET_ONE
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [clp_pkg::CLP_DATA_W-1:0] wdata,
    // stored word and the value it takes at the next edge
    output logic [clp_pkg::CLP_DATA_W-1:0] word,
    output logic [clp_pkg::CLP_DATA_W-1:0] next_word
);
    import clp_pkg::*;

    // parity and reserved bits are stored like any other, nothing is checked
    always_comb begin
        next_word = word;
        if (wr_en) begin
            next_word = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word <= RESET_VALUE;
        end else begin
            word <= next_word;
        end
    end
endmodule : clp_word

// ===== clp_regs_properties.sv
// checker for the closed-loop settings register slice
// assumes it is bound to clp_regs and sees only its ports
`timescale 1ns/10ps
module clp_regs_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [clp_pkg::CLP_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [clp_pkg::CLP_DATA_W-1:0] reg_wdata,
    input wire logic [clp_pkg::CLP_DATA_W-1:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    // decoded controls
    input wire logic [6:0] switching_frequency_khz,
    input wire logic [4:0] switching_frequency_sel,
    input wire clp_pkg::clp_mod_t modulation_side_sel,
    input wire logic modulation_invalid,
    input wire logic complementary_mode,
    input wire logic lead_sign,
    input wire logic [7:0] lead_magnitude,
    input wire logic [12:0] lead_angle_centideg,
    input wire logic [2:0] stop_method,
    input wire logic [3:0] cycle_current_limit
);
    import clp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic unmapped;
    assign req = reg_wr | reg_rd;
    assign unmapped = (reg_addr != CLP_ADDR_ONE) && (reg_addr != CLP_ADDR_TWO);
    a_ack_after_req: assert property (req |=> reg_ack) else $error("no ack after request");
    a_no_stray_ack: assert property (!req |=> !reg_ack) else $error("ack without request");
    a_err_unmapped: assert property (req |=> reg_err == $past(unmapped)) else $error("bad error flag");
    a_freq_decode: assert property (switching_frequency_khz == ((switching_frequency_sel < 5'h10) ?
        {2'h0, switching_frequency_sel} + 7'h05 : {2'h0, switching_frequency_sel - 5'h10} * 7'h05 + 7'h19))
        else $error("frequency decode wrong");
    a_mod_flag: assert property (modulation_invalid == (modulation_side_sel == CLP_MOD_INVALID))
        else $error("modulation flag wrong");
    a_lead_value: assert property (lead_angle_centideg == (lead_sign ? {5'h00, lead_magnitude} * 13'h00C
        : 13'h0000 - {5'h00, lead_magnitude} * 13'h00C)) else $error("lead angle wrong");
    a_word_one_fields: assert property (reg_wr && reg_addr == CLP_ADDR_ONE |=>
        {switching_frequency_sel, modulation_side_sel, complementary_mode, lead_sign, lead_magnitude}
        == $past(reg_wdata[17:1])) else $error("word one fields wrong");
    a_word_two_fields: assert property (reg_wr && reg_addr == CLP_ADDR_TWO |=>
        {stop_method, cycle_current_limit} == {$past(reg_wdata[20:18]), $past(reg_wdata[6:3])})
        else $error("word two fields wrong");
    a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == CLP_READ_NONE)
        else $error("unmapped read not zero");
    c_write_two: cover property (reg_wr && reg_addr == CLP_ADDR_TWO);
    c_unmapped_read: cover property (reg_rd && unmapped);
    c_mod_invalid: cover property (modulation_invalid);
endmodule : clp_regs_properties
bind clp_regs clp_regs_properties u_props (.*);

// ===== clp_regs_tb.sv
// self-checking bench for the closed-loop settings register slice
// assumes clp_pkg, clp_regs and the bound checker are compiled first
`timescale 1ns/10ps
module clp_regs_tb;
    import clp_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, reg_ack, reg_err, modulation_invalid, complementary_mode, lead_sign;
    logic feedback_output_config, surge_guard_enable;
    logic [7:0] reg_addr, lead_magnitude;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [6:0] switching_frequency_khz;
    logic [4:0] switching_frequency_sel;
    logic [1:0] feedback_output_select;
    logic [3:0] feedback_output_divider, stop_brake_time, cycle_current_limit;
    logic [2:0] feedback_backemf_threshold, stop_method, active_spindown_threshold, brake_duty_limit;
    logic [12:0] lead_angle_centideg;
    clp_mod_t modulation_side_sel;
    int mismatches, n_checks, m;
    clp_regs DUT (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one strobe, then sample the answer in the ack cycle
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic err);
        @(posedge clk) #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = wd;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk({reg_ack, reg_err}, {1'b1, err});
    endtask : access
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        access(1'b0, a, 32'h00000000, err);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic wrap_up;
        if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        mismatches++;
        wrap_up;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, mismatches, n_checks} = '0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(CLP_ADDR_ONE, CLP_RESET_ONE, 1'b0);
        rd(CLP_ADDR_TWO, CLP_RESET_TWO, 1'b0);
        chk(switching_frequency_khz, 32'h00000005);
        for (int i = 0; i < 2; i++) begin
            d = i ? 32'hFFFFFFFF : 32'hA5A5A5A5;
            access(1'b1, CLP_ADDR_TWO, d, 1'b0);
            chk({feedback_output_select, feedback_output_divider, feedback_output_config, feedback_backemf_threshold,
                stop_method, stop_brake_time, active_spindown_threshold, brake_duty_limit, surge_guard_enable,
                cycle_current_limit}, {4'h0, d[30:3]});
            rd(CLP_ADDR_TWO, d, 1'b0);
        end
        for (int c = 0; c < 32; c++) begin
            m = c * 8 + 7;
            d = {c[0], 13'h0000, 5'(c), 2'(c), c[2], c[3], 8'(m), 1'b1};
            access(1'b1, CLP_ADDR_ONE, d, 1'b0);
            chk(switching_frequency_khz, 32'((c < 16) ? c + 5 : c * 5 - 55));
            chk({modulation_invalid, modulation_side_sel}, {c[1:0] == 2'h3, 2'(c)});
            chk({complementary_mode, lead_sign, lead_magnitude}, {c[2], c[3], 8'(m)});
            chk(lead_angle_centideg, {19'h00000, 13'(c[3] ? m * 12 : -m * 12)});
            rd(CLP_ADDR_ONE, d, 1'b0);
        end
        access(1'b1, 8'h8C, 32'h00000000, 1'b1);
        rd(8'h80, CLP_READ_NONE, 1'b1);
        rd(CLP_ADDR_TWO, 32'hFFFFFFFF, 1'b0);
        rd(CLP_ADDR_ONE, d, 1'b0);
        // second reset with word two full and word one holding the last pattern: everything returns to the reset decode
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(CLP_ADDR_ONE, CLP_RESET_ONE, 1'b0);
        rd(CLP_ADDR_TWO, CLP_RESET_TWO, 1'b0);
        chk(switching_frequency_khz, 32'h00000005);
        chk({modulation_invalid, modulation_side_sel, complementary_mode, lead_sign, lead_magnitude,
            lead_angle_centideg}, 32'h00000000);
        chk({feedback_output_select, feedback_output_divider, feedback_output_config, feedback_backemf_threshold,
            stop_method, stop_brake_time, active_spindown_threshold, brake_duty_limit, surge_guard_enable,
            cycle_current_limit}, 32'h00000000);
        wrap_up;
    end
endmodule : clp_regs_tb
